// [lmbc_consts.vh]
/*
 Constants of the link monitor and back-channel configuration slice:
 register indices, field positions, reset values and masks.
 Assumes byte address = 4 x register index on a 32-bit APB.
*/
`ifndef LMBC_CONSTS_VH
`define LMBC_CONSTS_VH

// Register indices (byte address is four times these)
`define LMBC_IDX_EQ_STAT 8'h3B
`define LMBC_IDX_THRESH 8'h41
`define LMBC_IDX_SPEED 8'h43
`define LMBC_IDX_BYPASS 8'h44
`define LMBC_IDX_PORT_SEL 8'h50
`define LMBC_IDX_INT_STS 8'h60
`define LMBC_IDX_INT_MSK 8'h61
`define LMBC_IDX_LOCK_STS 8'h62

// Reset values
`define LMBC_RST_THRESH 5'h03
`define LMBC_RST_SPEED 5'h00
`define LMBC_RST_BYPASS 8'h60

// Writable bits of the bypass register
`define LMBC_MSK_BYPASS 8'hEF

// Field positions
`define LMBC_THR_EN_BIT 4
`define LMBC_SPD_POCI_BIT 4
`define LMBC_SPD_CPOL_BIT 3
`define LMBC_BYP_BIT 0

// Back-channel speed mode codes
`define LMBC_MODE_NORMAL 3'h0
`define LMBC_MODE_GPIO1 3'h1
`define LMBC_MODE_GPIO2 3'h2
`define LMBC_MODE_GPIO4 3'h3
`define LMBC_MODE_FWD_SPI 3'h6
`define LMBC_MODE_REV_SPI 3'h7

// Interrupt bits
`define LMBC_INT_LOST 0
`define LMBC_INT_ERR 1
`endif

// [lmbc_sync.v]
/*
 Two-stage synchroniser for a bundle of unrelated pin levels.
 Assumes each bit is a slow level; no bus coherency is kept.
*/
`timescale 1ns/1ns
module lmbc_sync #(
   parameter W = 8
) (
   input wire clk,
   input wire rst_n,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_r;

   // First stage feeds only the second stage
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// [lmbc_errcnt.v]
/*
 Link error accumulator with a trip flag.
 Assumes tick is a one-cycle pixel-clock enable and clr is a level.
*/
`timescale 1ns/1ns
module lmbc_errcnt #(
   parameter W = 4
) (
   input wire clk,
   input wire rst_n,
   input wire tick,
   input wire err,
   input wire cnt_en,
   input wire [W-1:0] thr,
   input wire clr,
   output reg trip,
   output reg [W-1:0] count
);
   wire [W:0] inc;

   assign inc = {1'b0, count} + {{W{1'b0}}, 1'b1};

   // Count only on pixel-clock ticks; saturate instead of wrapping
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trip <= 1'b0;
         count <= {W{1'b0}};
      end else if (clr) begin
         trip <= 1'b0;
         count <= {W{1'b0}};
      end else if (tick && err && !trip) begin
         if (!cnt_en) begin
            trip <= 1'b1;
         end else begin
            if (inc >= {1'b0, thr}) begin
               trip <= 1'b1;
            end
            if (!inc[W]) begin
               count <= inc[W-1:0];
            end
         end
      end
   end
endmodule

// [lmbc_top.v]
/*
 Link monitor and back-channel configuration slice with an APB slave:
 equalizer readback, link error threshold and lock, speed mode decode,
 SPI edge selection and peripheral-out driver control, interrupts.
 Assumes adaptive settings and POCI data come from logic on MCLK; all
 other link signals are pins and are synchronised here.
*/
`timescale 1ns/1ns
`include "lmbc_consts.vh"
module lmbc_top #(
   parameter EQ_W = 6,
   parameter THR_W = 4
) (
   input wire MCLK,
   input wire ARST_N,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [9:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   input wire [EQ_W-1:0] AEQ_P0_SETTING,
   input wire [EQ_W-1:0] AEQ_P1_SETTING,
   output reg [EQ_W-1:0] EQ_P0_DRIVE,
   output reg [EQ_W-1:0] EQ_P1_DRIVE,
   input wire PIXEL_CLK_PIN,
   input wire FRAME_CLOCK_BIT_FIRST_ERR,
   input wire FRAME_CLOCK_BIT_SECOND_ERR,
   input wire AUXILIARY_CONTROL_LANE_ERR,
   input wire CDR_LOCK_PIN,
   output reg LOCK,
   input wire SPI_SCLK_PIN,
   input wire SPI_CS_PIN,
   input wire SPI_PICO_PIN,
   input wire POCI_DATA,
   output reg SPI_POCI_O,
   output reg SPI_POCI_OE,
   output reg SPI_RX_BIT,
   output reg SPI_RX_STB,
   output reg [2:0] BACKCHANNEL_SPEED_MODE,
   output reg [2:0] HS_GPIO_COUNT,
   output reg FWD_SPI_EN,
   output reg REV_SPI_EN,
   output reg IRQ
);
   // Reset release
   reg [1:0] rst_sync_r;
   wire rst_n;

   // Synchronised pins
   wire [7:0] pins_raw;
   wire [7:0] pins_s;
   wire pclk_s;
   wire err_any;
   wire cdr_lock_s;
   wire sclk_s;
   wire cs_s;
   wire pico_s;
   reg pclk_d_r;
   reg sclk_d_r;
   wire pclk_tick;
   wire sclk_rise;
   wire sclk_fall;

   // Software registers
   reg thr_en_r;
   reg [THR_W-1:0] thr_r;
   reg poci_sel_r;
   reg cpol_r;
   reg [2:0] mode_r;
   reg [7:0] byp0_r;
   reg [7:0] byp1_r;
   reg port1_r;
   reg [1:0] int_sts_r;
   reg [1:0] int_msk_r;

   // Bus decode
   wire setup;
   wire wr_acc;
   wire aligned;
   wire [7:0] idx;
   reg [7:0] rd_nxt;
   reg hit_nxt;

   // Equalizer settings
   wire [EQ_W-1:0] eq0;
   wire [EQ_W-1:0] eq1;
   wire [EQ_W-1:0] eq_sel;

   // Lock tracking
   wire trip;
   wire [THR_W-1:0] err_count;
   reg lost_r;
   wire lost_ev;
   wire err_ev;
   wire [1:0] int_set;
   wire [1:0] int_clr;

   // SPI edge and mode terms
   wire launch;
   wire capture;
   reg [2:0] hs_cnt_nxt;
   reg fwd_nxt;
   reg rev_nxt;

   // Async assert, clocked release of the internal reset
   always @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // All pin levels pass two flops before use
   assign pins_raw = {SPI_PICO_PIN, SPI_CS_PIN, SPI_SCLK_PIN, CDR_LOCK_PIN,
                      AUXILIARY_CONTROL_LANE_ERR, FRAME_CLOCK_BIT_SECOND_ERR,
                      FRAME_CLOCK_BIT_FIRST_ERR, PIXEL_CLK_PIN};

   lmbc_sync #(
      .W(8)
   ) u_sync (
      .clk(MCLK),
      .rst_n(rst_n),
      .d(pins_raw),
      .q(pins_s)
   );

   assign pclk_s = pins_s[0];
   assign err_any = |pins_s[3:1];
   assign cdr_lock_s = pins_s[4];
   assign sclk_s = pins_s[5];
   assign cs_s = pins_s[6];
   assign pico_s = pins_s[7];

   // Edge history of the slow clocks, taken after the synchroniser
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         pclk_d_r <= 1'b0;
         sclk_d_r <= 1'b0;
      end else begin
         pclk_d_r <= pclk_s;
         sclk_d_r <= sclk_s;
      end
   end

   // Recovered pixel clock becomes a one-cycle enable
   assign pclk_tick = pclk_s & ~pclk_d_r;
   assign sclk_rise = sclk_s & ~sclk_d_r;
   assign sclk_fall = ~sclk_s & sclk_d_r;

   // APB phases; zero wait states, so access equals the PREADY cycle
   assign setup = PSEL & ~PENABLE;
   assign wr_acc = PSEL & PENABLE & PWRITE & PREADY & ~PSLVERR;
   assign aligned = (PADDR[1:0] == 2'b00);
   assign idx = PADDR[9:2];

   // Bypass copies: stage one sits above stage two in the status
   assign eq0 = byp0_r[`LMBC_BYP_BIT] ? {byp0_r[3:1], byp0_r[7:5]}
                                     : AEQ_P0_SETTING;
   assign eq1 = byp1_r[`LMBC_BYP_BIT] ? {byp1_r[3:1], byp1_r[7:5]}
                                     : AEQ_P1_SETTING;
   assign eq_sel = port1_r ? eq1 : eq0;

   // Read mux; unused bit positions stay zero
   always @* begin
      rd_nxt = 8'h00;
      hit_nxt = aligned;
      case (idx)
         `LMBC_IDX_EQ_STAT: begin
            rd_nxt = {2'b00, eq_sel};
         end
         `LMBC_IDX_THRESH: begin
            rd_nxt = {3'b000, thr_en_r, thr_r};
         end
         `LMBC_IDX_SPEED: begin
            rd_nxt = {3'b000, poci_sel_r, cpol_r, mode_r};
         end
         `LMBC_IDX_BYPASS: begin
            rd_nxt = port1_r ? byp1_r : byp0_r;
         end
         `LMBC_IDX_PORT_SEL: begin
            rd_nxt = {7'h00, port1_r};
         end
         `LMBC_IDX_INT_STS: begin
            rd_nxt = {6'h00, int_sts_r};
         end
         `LMBC_IDX_INT_MSK: begin
            rd_nxt = {6'h00, int_msk_r};
         end
         `LMBC_IDX_LOCK_STS: begin
            rd_nxt = {err_count, 2'b00, lost_r, LOCK};
         end
         default: begin
            hit_nxt = 1'b0;
         end
      endcase
   end

   // Answer is registered in setup so every bus output is a flop
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         PRDATA <= 32'h00000000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else if (setup) begin
         PRDATA <= (hit_nxt && !PWRITE) ? {24'h000000, rd_nxt} : 32'h00000000;
         PREADY <= 1'b1;
         PSLVERR <= ~hit_nxt;
      end else begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
   end

   // Writable configuration; the status index is read-only
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         {thr_en_r, thr_r} <= `LMBC_RST_THRESH;
         {poci_sel_r, cpol_r, mode_r} <= `LMBC_RST_SPEED;
         byp0_r <= `LMBC_RST_BYPASS;
         byp1_r <= `LMBC_RST_BYPASS;
         port1_r <= 1'b0;
         int_msk_r <= 2'b00;
      end else if (wr_acc) begin
         case (idx)
            `LMBC_IDX_THRESH: begin
               thr_en_r <= PWDATA[`LMBC_THR_EN_BIT];
               thr_r <= PWDATA[THR_W-1:0];
            end
            `LMBC_IDX_SPEED: begin
               poci_sel_r <= PWDATA[`LMBC_SPD_POCI_BIT];
               cpol_r <= PWDATA[`LMBC_SPD_CPOL_BIT];
               mode_r <= PWDATA[2:0];
            end
            `LMBC_IDX_BYPASS: begin
               // Port select steers which copy takes the write
               if (port1_r) begin
                  byp1_r <= PWDATA[7:0] & `LMBC_MSK_BYPASS;
               end else begin
                  byp0_r <= PWDATA[7:0] & `LMBC_MSK_BYPASS;
               end
            end
            `LMBC_IDX_PORT_SEL: begin
               port1_r <= PWDATA[0];
            end
            `LMBC_IDX_INT_MSK: begin
               int_msk_r <= PWDATA[1:0];
            end
            default: begin
               port1_r <= port1_r;
            end
         endcase
      end
   end

   // Error accumulation restarts whenever the link relocks
   lmbc_errcnt #(
      .W(THR_W)
   ) u_errcnt (
      .clk(MCLK),
      .rst_n(rst_n),
      .tick(pclk_tick),
      .err(err_any),
      .cnt_en(thr_en_r),
      .thr(thr_r),
      .clr(~cdr_lock_s),
      .trip(trip),
      .count(err_count)
   );

   // Lock falls on trip and stays low until the recovery loop drops
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         lost_r <= 1'b0;
         LOCK <= 1'b0;
      end else begin
         lost_r <= trip;
         LOCK <= cdr_lock_s & ~trip;
      end
   end

   // Events: first cycle of loss, and any error at a pixel tick
   assign lost_ev = trip & ~lost_r;
   assign err_ev = pclk_tick & err_any;
   assign int_set = {err_ev, lost_ev};
   assign int_clr = (wr_acc && idx == `LMBC_IDX_INT_STS) ? PWDATA[1:0] : 2'b00;

   // Sticky status, write one to clear; a new event beats the clear
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         int_sts_r <= 2'b00;
         IRQ <= 1'b0;
      end else begin
         int_sts_r <= (int_sts_r & ~int_clr) | int_set;
         IRQ <= |(((int_sts_r & ~int_clr) | int_set) & int_msk_r);
      end
   end

   // Analog equalizer takes the same value software reads back
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         EQ_P0_DRIVE <= {EQ_W{1'b0}};
         EQ_P1_DRIVE <= {EQ_W{1'b0}};
      end else begin
         EQ_P0_DRIVE <= eq0;
         EQ_P1_DRIVE <= eq1;
      end
   end

   // Speed mode decode; reserved codes fall back to the normal frame
   always @* begin
      hs_cnt_nxt = 3'h0;
      fwd_nxt = 1'b0;
      rev_nxt = 1'b0;
      case (mode_r)
         `LMBC_MODE_NORMAL: begin
            hs_cnt_nxt = 3'h0;
         end
         `LMBC_MODE_GPIO1: begin
            hs_cnt_nxt = 3'h1;
         end
         `LMBC_MODE_GPIO2: begin
            hs_cnt_nxt = 3'h2;
         end
         `LMBC_MODE_GPIO4: begin
            hs_cnt_nxt = 3'h4;
         end
         `LMBC_MODE_FWD_SPI: begin
            fwd_nxt = 1'b1;
         end
         `LMBC_MODE_REV_SPI: begin
            rev_nxt = 1'b1;
         end
         default: begin
            hs_cnt_nxt = 3'h0;
         end
      endcase
   end

   // Registered mode outputs toward the back-channel framer
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         BACKCHANNEL_SPEED_MODE <= 3'h0;
         HS_GPIO_COUNT <= 3'h0;
         FWD_SPI_EN <= 1'b0;
         REV_SPI_EN <= 1'b0;
      end else begin
         BACKCHANNEL_SPEED_MODE <= mode_r;
         HS_GPIO_COUNT <= hs_cnt_nxt;
         FWD_SPI_EN <= fwd_nxt;
         REV_SPI_EN <= rev_nxt;
      end
   end

   // Edge choice by polarity; sampled edges lag the pin by 2 cycles
   assign launch = cpol_r ? sclk_rise : sclk_fall;
   assign capture = cpol_r ? sclk_fall : sclk_rise;

   // PICO capture only while selected in an SPI mode; POCI launch in reverse SPI mode, selected or not
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         SPI_POCI_O <= 1'b0;
         SPI_POCI_OE <= 1'b0;
         SPI_RX_BIT <= 1'b0;
         SPI_RX_STB <= 1'b0;
      end else begin
         if (rev_nxt && launch) begin
            SPI_POCI_O <= POCI_DATA;
         end
         // Bused peripherals need the driver off while unselected
         SPI_POCI_OE <= rev_nxt & (~poci_sel_r | cs_s);
         SPI_RX_STB <= (fwd_nxt | rev_nxt) & cs_s & capture;
         if ((fwd_nxt || rev_nxt) && cs_s && capture) begin
            SPI_RX_BIT <= pico_s;
         end
      end
   end
endmodule

// [lmbc_top_sva.sv]
/*
 Checker for lmbc_top: APB handshake, read data shape, speed mode
 decode, POCI driver enable and SPI capture strobes.
 Assumes it sees only the top ports and is bound to every lmbc_top.
*/
`timescale 1ns/1ns
module lmbc_top_sva #(
   parameter EQ_W = 6,
   parameter THR_W = 4
) (
   input wire MCLK,
   input wire ARST_N,
   input wire PSEL,
   input wire PENABLE,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR,
   input wire [2:0] BACKCHANNEL_SPEED_MODE,
   input wire [2:0] HS_GPIO_COUNT,
   input wire FWD_SPI_EN,
   input wire REV_SPI_EN,
   input wire SPI_POCI_OE,
   input wire SPI_RX_STB,
   input wire LOCK
);
   wire [2:0] mode = BACKCHANNEL_SPEED_MODE;
   wire [2:0] gcnt_exp;
   // Expected GPIO lanes per mode; reserved codes carry none
   assign gcnt_exp = (mode == 3'h1) ? 3'h1 : (mode == 3'h2) ? 3'h2 :
      (mode == 3'h3) ? 3'h4 : 3'h0;

   default clocking @(posedge MCLK); endclocking
   default disable iff (!ARST_N);

   // Zero-wait slave, one ready pulse per transfer
   a_setup_gets_ready: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready after setup");
   a_ready_one_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   a_ready_in_access: assert property
      (PREADY |-> PSEL && PENABLE && $past(PSEL) && !$past(PENABLE))
      else $error("ready outside access cycle");
   a_error_zero_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
      else $error("error response with data");
   a_rdata_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
      else $error("read data above byte not zero");
   // Decode is checked once the mode copy has settled a cycle
   a_gpio_count_map: assert property ($stable(mode) |-> HS_GPIO_COUNT == gcnt_exp)
      else $error("gpio count does not match mode");
   a_spi_mode_decode: assert property ($stable(mode) |->
      FWD_SPI_EN == (mode == 3'h6) && REV_SPI_EN == (mode == 3'h7))
      else $error("spi enables do not match mode");
   a_poci_only_rev: assert property (SPI_POCI_OE |-> REV_SPI_EN || $past(REV_SPI_EN))
      else $error("poci driven outside reverse mode");
   a_capture_in_spi: assert property (SPI_RX_STB |->
      FWD_SPI_EN || REV_SPI_EN || $past(FWD_SPI_EN) || $past(REV_SPI_EN))
      else $error("capture strobe outside spi mode");

   c_slave_error: cover property (PSLVERR);
   c_lock_drop: cover property ($fell(LOCK));
   c_poci_drive: cover property (SPI_POCI_OE && REV_SPI_EN);
   c_capture: cover property (SPI_RX_STB);
endmodule

bind lmbc_top lmbc_top_sva #(.EQ_W(EQ_W), .THR_W(THR_W)) u_sva (
   .MCLK(MCLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .BACKCHANNEL_SPEED_MODE(BACKCHANNEL_SPEED_MODE), .HS_GPIO_COUNT(HS_GPIO_COUNT),
   .FWD_SPI_EN(FWD_SPI_EN), .REV_SPI_EN(REV_SPI_EN), .SPI_POCI_OE(SPI_POCI_OE),
   .SPI_RX_STB(SPI_RX_STB), .LOCK(LOCK));

// [lmbc_top_tb.sv]
/*
 Self-checking bench for lmbc_top: registers over APB, link errors,
 lock and interrupts, speed modes, SPI edges and POCI driver enable.
 Assumes the register indices of lmbc_consts.vh and byte = 4 x index.
*/
`timescale 1ns/1ns
`include "lmbc_consts.vh"
module lmbc_top_tb;
   logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [9:0] paddr = 0;
   logic [31:0] pwdata = 0, rdv;
   logic pix = 0, e1 = 0, e2 = 0, ea = 0, cdr = 0, sclk = 0, cs = 0, pico = 0, pocd = 0;
   logic erv;
   logic [5:0] aeq0 = 6'h2A;
   wire [31:0] prdata;
   wire [5:0] drv0, drv1;
   wire [2:0] mode, gcnt;
   wire pready, pslverr, lock, poci_o, oe, rx_bit, rx_stb, fwd, rev, irq;
   int miscompares = 0, check_count = 0, n_stb;

   lmbc_top u_dut (.MCLK(mclk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .AEQ_P0_SETTING(aeq0),
      .AEQ_P1_SETTING(6'h0C), .EQ_P0_DRIVE(drv0), .EQ_P1_DRIVE(drv1),
      .PIXEL_CLK_PIN(pix), .FRAME_CLOCK_BIT_FIRST_ERR(e1),
      .FRAME_CLOCK_BIT_SECOND_ERR(e2), .AUXILIARY_CONTROL_LANE_ERR(ea),
      .CDR_LOCK_PIN(cdr), .LOCK(lock), .SPI_SCLK_PIN(sclk), .SPI_CS_PIN(cs),
      .SPI_PICO_PIN(pico), .POCI_DATA(pocd), .SPI_POCI_O(poci_o), .SPI_POCI_OE(oe),
      .SPI_RX_BIT(rx_bit), .SPI_RX_STB(rx_stb), .BACKCHANNEL_SPEED_MODE(mode),
      .HS_GPIO_COUNT(gcnt), .FWD_SPI_EN(fwd), .REV_SPI_EN(rev), .IRQ(irq));

   // 125 MHz clock
   always #4 mclk = ~mclk;

   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // One APB transfer; waits for ready, the watchdog catches a dead slave
   task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge mclk);
      penable <= 1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
   endtask

   task wr(input logic [7:0] i, input logic [7:0] d);
      apb(1, i, d);
   endtask

   task rd(input logic [7:0] i, input logic [31:0] e);
      apb(0, i, 8'h00);
      chk(rdv, e);
      chk(erv, 0);
   endtask

   // One pixel clock period with the given lanes in error
   task tick(input logic [2:0] e);
      {ea, e2, e1} <= e;
      pix <= 1;
      repeat (6) @(posedge mclk);
      {ea, e2, e1} <= 3'h0;
      pix <= 0;
      repeat (6) @(posedge mclk);
   endtask

   // Moves the SPI clock and counts capture strobes over eight cycles
   task sedge(input logic v);
      sclk <= v;
      n_stb = 0;
      repeat (8) begin
         @(posedge mclk);
         if (rx_stb === 1'b1) n_stb++;
      end
   endtask

   task t_reset_values;
      rd(`LMBC_IDX_THRESH, 32'h03);
      rd(`LMBC_IDX_SPEED, 32'h00);
      rd(`LMBC_IDX_BYPASS, 32'h60);
      apb(0, 8'h10, 8'h00);
      chk(erv, 1);
      chk(rdv, 0);
      wr(`LMBC_IDX_EQ_STAT, 8'h3F);
      rd(`LMBC_IDX_EQ_STAT, 32'h2A);
   endtask

   task t_equalizer;
      chk(drv0, 6'h2A);
      wr(`LMBC_IDX_BYPASS, 8'hB5);
      rd(`LMBC_IDX_BYPASS, 32'hA5);
      rd(`LMBC_IDX_EQ_STAT, 32'h15);
      chk(drv0, 6'h15);
      wr(`LMBC_IDX_PORT_SEL, 8'h01);
      rd(`LMBC_IDX_EQ_STAT, 32'h0C);
      chk(drv1, 6'h0C);
      wr(`LMBC_IDX_BYPASS, 8'h53);
      rd(`LMBC_IDX_BYPASS, 32'h43);
      rd(`LMBC_IDX_EQ_STAT, 32'h0A);
      chk(drv1, 6'h0A);
      wr(`LMBC_IDX_PORT_SEL, 8'h00);
      rd(`LMBC_IDX_BYPASS, 32'hA5);
      wr(`LMBC_IDX_BYPASS, 8'hB4);
      rd(`LMBC_IDX_EQ_STAT, 32'h2A);
      // A new loop setting must reach both readback and analog drive
      aeq0 <= 6'h13;
      repeat (2) @(posedge mclk);
      chk(drv0, 6'h13);
      rd(`LMBC_IDX_EQ_STAT, 32'h13);
   endtask

   task t_errors;
      cdr <= 1;
      repeat (8) @(posedge mclk);
      chk(lock, 1);
      wr(`LMBC_IDX_THRESH, 8'h12);
      rd(`LMBC_IDX_THRESH, 32'h12);
      wr(`LMBC_IDX_INT_MSK, 8'h01);
      tick(3'b001);
      chk(lock, 1);
      tick(3'b100);
      chk(lock, 0);
      chk(irq, 1);
      rd(`LMBC_IDX_LOCK_STS, 32'h22);
      rd(`LMBC_IDX_INT_STS, 32'h03);
      wr(`LMBC_IDX_INT_STS, 8'h03);
      rd(`LMBC_IDX_INT_STS, 32'h00);
      chk(irq, 0);
      // Dropping recovery lock clears the trip
      cdr <= 0;
      repeat (8) @(posedge mclk);
      cdr <= 1;
      repeat (8) @(posedge mclk);
      chk(lock, 1);
      wr(`LMBC_IDX_THRESH, 8'hEF);
      rd(`LMBC_IDX_THRESH, 32'h0F);
      wr(`LMBC_IDX_INT_MSK, 8'h00);
      tick(3'b010);
      chk(lock, 0);
      chk(irq, 0);
      wr(`LMBC_IDX_INT_MSK, 8'h01);
      repeat (2) @(posedge mclk);
      chk(irq, 1);
      wr(`LMBC_IDX_INT_STS, 8'h03);
      repeat (2) @(posedge mclk);
      chk(irq, 0);
   endtask

   task t_modes;
      for (int m = 0; m < 8; m++) begin
         wr(`LMBC_IDX_SPEED, m[7:0]);
         repeat (3) @(posedge mclk);
         chk(mode, m);
         chk(gcnt, m == 1 ? 1 : m == 2 ? 2 : m == 3 ? 4 : 0);
         chk({fwd, rev}, m == 6 ? 2 : m == 7 ? 1 : 0);
         chk(oe, m == 7);
      end
   endtask

   task t_spi;
      wr(`LMBC_IDX_SPEED, 8'hF7);
      rd(`LMBC_IDX_SPEED, 32'h17);
      repeat (4) @(posedge mclk);
      chk(oe, 0);
      cs <= 1;
      pico <= 1;
      pocd <= 1;
      repeat (5) @(posedge mclk);
      chk(oe, 1);
      sedge(1);
      chk(n_stb, 1);
      chk(rx_bit, 1);
      sedge(0);
      chk(n_stb, 0);
      chk(poci_o, 1);
      wr(`LMBC_IDX_SPEED, 8'h0F);
      cs <= 0;
      repeat (5) @(posedge mclk);
      chk(oe, 1);
      cs <= 1;
      pocd <= 0;
      pico <= 0;
      sedge(1);
      chk(n_stb, 0);
      chk(poci_o, 0);
      sedge(0);
      chk(n_stb, 1);
      chk(rx_bit, 0);
      cs <= 0;
   endtask

   task tally_and_finish;
      if (miscompares == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence after five reset cycles
   initial begin
      repeat (5) @(posedge mclk);
      arst_n <= 1;
      repeat (4) @(posedge mclk);
      t_reset_values;
      t_equalizer;
      t_errors;
      t_modes;
      t_spi;
      tally_and_finish;
   end

   // Watchdog, well beyond the few hundred cycles the tests need
   initial begin
      #100000;
      miscompares++;
      tally_and_finish;
   end
endmodule
